// *** hdl/expansion_bus_gpio_ports.sv ***
// Expansion bus port block: two 8-bit ports and one 6-bit port with
// per-bit direction, shared with the external memory bus.
// Assumes a byte register port with read data one cycle after the strobe,
// and an external bus controller that drives the alternate functions.
`timescale 1ns/1ps
module expansion_bus_gpio_ports (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [gpio_pkg::ADDR_W-1:0] addr,
  input wire logic [gpio_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic bit_access,
  input wire logic [gpio_pkg::IDX_W-1:0] bit_index,
  output logic [gpio_pkg::DATA_W-1:0] rdata,
  input wire logic [gpio_pkg::WIDE_W-1:0] port4_pin_in,
  output logic [gpio_pkg::WIDE_W-1:0] port4_pin_out,
  output logic [gpio_pkg::WIDE_W-1:0] port4_pin_oe,
  input wire logic [gpio_pkg::WIDE_W-1:0] port5_pin_in,
  output logic [gpio_pkg::WIDE_W-1:0] port5_pin_out,
  output logic [gpio_pkg::WIDE_W-1:0] port5_pin_oe,
  input wire logic [gpio_pkg::NARROW_W-1:0] port6_pin_in,
  output logic [gpio_pkg::NARROW_W-1:0] port6_pin_out,
  output logic [gpio_pkg::NARROW_W-1:0] port6_pin_oe,
  input wire logic [gpio_pkg::AD_W-1:0] multiplexed_addr_data_out,
  input wire logic [gpio_pkg::AD_W-1:0] multiplexed_addr_data_oe,
  output logic [gpio_pkg::AD_W-1:0] multiplexed_addr_data_in,
  input wire logic [gpio_pkg::NARROW_W-1:0] upper_address_lines,
  output logic [gpio_pkg::MM_W-1:0] memory_expansion_control
);

  localparam int WW = gpio_pkg::WIDE_W;
  localparam int NW = gpio_pkg::NARROW_W;
  localparam int DW = gpio_pkg::DATA_W;

  ////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= gpio_pkg::SYNC_CLEAR;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  gpio_pkg::reg_sel_t sel;

  always_comb begin
    unique case (addr)
      gpio_pkg::PORT4_LATCH_ADDR: begin
        sel = gpio_pkg::SEL_P4_LATCH;
      end
      gpio_pkg::PORT5_LATCH_ADDR: begin
        sel = gpio_pkg::SEL_P5_LATCH;
      end
      gpio_pkg::PORT6_LATCH_ADDR: begin
        sel = gpio_pkg::SEL_P6_LATCH;
      end
      gpio_pkg::PORT4_DIR_ADDR: begin
        sel = gpio_pkg::SEL_P4_DIR;
      end
      gpio_pkg::PORT5_DIR_ADDR: begin
        sel = gpio_pkg::SEL_P5_DIR;
      end
      gpio_pkg::PORT6_DIR_ADDR: begin
        sel = gpio_pkg::SEL_P6_DIR;
      end
      gpio_pkg::MEM_EXP_CTRL_ADDR: begin
        sel = gpio_pkg::SEL_MEM_EXP;
      end
      default: begin
        sel = gpio_pkg::SEL_NONE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte or single bit write shaping

  logic [DW-1:0] wr_mask;
  logic [DW-1:0] wr_value;

  always_comb begin
    if (bit_access) begin
      wr_mask = DW'(gpio_pkg::BIT_ZERO_MASK << bit_index);
      wr_value = {DW{wdata[0]}};
    end else begin
      wr_mask = gpio_pkg::BYTE_ALL;
      wr_value = wdata;
    end
  end

  logic p4_latch_we;
  logic p5_latch_we;
  logic p6_latch_we;
  logic p4_dir_we;
  logic p5_dir_we;
  logic p6_dir_we;
  logic mm_we;

  assign p4_latch_we = wr_stb && (sel == gpio_pkg::SEL_P4_LATCH);
  assign p5_latch_we = wr_stb && (sel == gpio_pkg::SEL_P5_LATCH);
  assign p6_latch_we = wr_stb && (sel == gpio_pkg::SEL_P6_LATCH);
  assign p4_dir_we = wr_stb && (sel == gpio_pkg::SEL_P4_DIR);
  assign p5_dir_we = wr_stb && (sel == gpio_pkg::SEL_P5_DIR);
  assign p6_dir_we = wr_stb && (sel == gpio_pkg::SEL_P6_DIR);
  assign mm_we = wr_stb && (sel == gpio_pkg::SEL_MEM_EXP);

  ////////////////////////////////////////////////////////////////////////
  // Memory expansion control

  logic [gpio_pkg::MM_W-1:0] mm_next;

  always_comb begin
    mm_next = memory_expansion_control;
    if (mm_we) begin
      mm_next = (memory_expansion_control & ~wr_mask[gpio_pkg::MM_W-1:0])
        | (wr_value[gpio_pkg::MM_W-1:0] & wr_mask[gpio_pkg::MM_W-1:0]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memory_expansion_control <= gpio_pkg::MM_RESET;
    end else begin
      memory_expansion_control <= mm_next;
    end
  end

  logic ad_low_sel;
  logic ad_high_sel;
  logic upper_sel;

  // Selection feeds only the pin muxes; direction bits are left alone
  assign ad_low_sel =
    memory_expansion_control[gpio_pkg::MM_AD_LOW_BIT];
  assign ad_high_sel =
    memory_expansion_control[gpio_pkg::MM_AD_HIGH_BIT];
  assign upper_sel =
    memory_expansion_control[gpio_pkg::MM_UPPER_ADDR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Ports; none has a pull-up control, pins are plain drive and enable

  logic [WW-1:0] p4_rd;
  logic [WW-1:0] p5_rd;
  logic [NW-1:0] p6_rd;
  logic [WW-1:0] p4_dir;
  logic [WW-1:0] p5_dir;
  logic [NW-1:0] p6_dir;

  port_slice #(
    .WIDTH(WW),
    .LATCH_INIT(gpio_pkg::LATCH_RESET),
    .DIR_INIT(gpio_pkg::WIDE_DIR_RESET)
  ) u_port4 (
    .clk(core_clk),
    .rst_n(rst_n),
    .latch_we(p4_latch_we),
    .dir_we(p4_dir_we),
    .wmask(wr_mask),
    .wdata(wr_value),
    .alt_sel(ad_low_sel),
    .alt_out(multiplexed_addr_data_out[WW-1:0]),
    .alt_oe(multiplexed_addr_data_oe[WW-1:0]),
    .pin_in(port4_pin_in),
    .pin_out(port4_pin_out),
    .pin_oe(port4_pin_oe),
    .rd_value(p4_rd),
    .dir_value(p4_dir)
  );

  port_slice #(
    .WIDTH(WW),
    .LATCH_INIT(gpio_pkg::LATCH_RESET),
    .DIR_INIT(gpio_pkg::WIDE_DIR_RESET)
  ) u_port5 (
    .clk(core_clk),
    .rst_n(rst_n),
    .latch_we(p5_latch_we),
    .dir_we(p5_dir_we),
    .wmask(wr_mask),
    .wdata(wr_value),
    .alt_sel(ad_high_sel),
    .alt_out(multiplexed_addr_data_out[gpio_pkg::AD_W-1:WW]),
    .alt_oe(multiplexed_addr_data_oe[gpio_pkg::AD_W-1:WW]),
    .pin_in(port5_pin_in),
    .pin_out(port5_pin_out),
    .pin_oe(port5_pin_oe),
    .rd_value(p5_rd),
    .dir_value(p5_dir)
  );

  // Upper address lines are outputs only while selected
  port_slice #(
    .WIDTH(NW),
    .LATCH_INIT(gpio_pkg::NARROW_LATCH_RESET),
    .DIR_INIT(gpio_pkg::NARROW_DIR_RESET)
  ) u_port6 (
    .clk(core_clk),
    .rst_n(rst_n),
    .latch_we(p6_latch_we),
    .dir_we(p6_dir_we),
    .wmask(wr_mask[NW-1:0]),
    .wdata(wr_value[NW-1:0]),
    .alt_sel(upper_sel),
    .alt_out(upper_address_lines),
    .alt_oe(gpio_pkg::UPPER_OE_ALL),
    .pin_in(port6_pin_in),
    .pin_out(port6_pin_out),
    .pin_oe(port6_pin_oe),
    .rd_value(p6_rd),
    .dir_value(p6_dir)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus input path back to the external bus controller

  logic [gpio_pkg::AD_W-1:0] ad_in_next;

  always_comb begin
    ad_in_next = {port5_pin_in, port4_pin_in};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      multiplexed_addr_data_in <= gpio_pkg::AD_ZERO;
    end else begin
      multiplexed_addr_data_in <= ad_in_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  logic [DW-1:0] rd_byte;
  logic [DW-1:0] rdata_next;

  always_comb begin
    unique case (sel)
      gpio_pkg::SEL_P4_LATCH: begin
        rd_byte = p4_rd;
      end
      gpio_pkg::SEL_P5_LATCH: begin
        rd_byte = p5_rd;
      end
      gpio_pkg::SEL_P6_LATCH: begin
        rd_byte = {gpio_pkg::NARROW_PAD, p6_rd};
      end
      gpio_pkg::SEL_P4_DIR: begin
        rd_byte = p4_dir;
      end
      gpio_pkg::SEL_P5_DIR: begin
        rd_byte = p5_dir;
      end
      gpio_pkg::SEL_P6_DIR: begin
        rd_byte = {gpio_pkg::NARROW_PAD, p6_dir};
      end
      gpio_pkg::SEL_MEM_EXP: begin
        rd_byte = {gpio_pkg::MM_PAD, memory_expansion_control};
      end
      gpio_pkg::SEL_NONE: begin
        rd_byte = gpio_pkg::BYTE_NONE;
      end
    endcase
  end

  always_comb begin
    rdata_next = gpio_pkg::BYTE_NONE;
    if (rd_stb) begin
      if (bit_access) begin
        rdata_next = {gpio_pkg::BIT_READ_PAD, rd_byte[bit_index]};
      end else begin
        rdata_next = rd_byte;
      end
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= gpio_pkg::BYTE_NONE;
    end else begin
      rdata <= rdata_next;
    end
  end

endmodule

// *** hdl/gpio_pkg.sv ***
// Package of the expansion bus port block: register map, reset values,
// field positions and the register select encoding.
// Assumes a byte-wide register port with 32-bit addresses.
package gpio_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 8;
  localparam int IDX_W = 3;
  localparam int WIDE_W = 8;
  localparam int NARROW_W = 6;
  localparam int AD_W = 16;
  localparam int MM_W = 3;

  // Register addresses
  localparam logic [ADDR_W-1:0] PORT4_LATCH_ADDR = 32'hffff_f008;
  localparam logic [ADDR_W-1:0] PORT5_LATCH_ADDR = 32'hffff_f00a;
  localparam logic [ADDR_W-1:0] PORT6_LATCH_ADDR = 32'hffff_f00c;
  localparam logic [ADDR_W-1:0] PORT4_DIR_ADDR = 32'h0fff_f028;
  localparam logic [ADDR_W-1:0] PORT5_DIR_ADDR = 32'h0fff_f02a;
  localparam logic [ADDR_W-1:0] PORT6_DIR_ADDR = 32'h0fff_f02c;
  localparam logic [ADDR_W-1:0] MEM_EXP_CTRL_ADDR = 32'hffff_f04c;

  // Reset values
  localparam logic [WIDE_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [NARROW_W-1:0] NARROW_LATCH_RESET = 6'h00;
  localparam logic [WIDE_W-1:0] WIDE_DIR_RESET = 8'hff;
  localparam logic [NARROW_W-1:0] NARROW_DIR_RESET = 6'h3f;
  localparam logic [MM_W-1:0] MM_RESET = 3'h0;

  // Memory expansion control fields
  localparam int MM_AD_LOW_BIT = 0;
  localparam int MM_AD_HIGH_BIT = 1;
  localparam int MM_UPPER_ADDR_BIT = 2;

  // Data helpers
  localparam logic [DATA_W-1:0] BYTE_ALL = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_NONE = 8'h00;
  localparam logic [DATA_W-1:0] BIT_ZERO_MASK = 8'h01;
  localparam logic [DATA_W-NARROW_W-1:0] NARROW_PAD = 2'h0;
  localparam logic [DATA_W-MM_W-1:0] MM_PAD = 5'h00;
  localparam logic [DATA_W-2:0] BIT_READ_PAD = 7'h00;
  localparam logic [AD_W-1:0] AD_ZERO = 16'h0000;
  localparam logic [NARROW_W-1:0] UPPER_OE_ALL = 6'h3f;
  localparam logic [1:0] SYNC_CLEAR = 2'h0;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_P4_LATCH = 3'b001,
    SEL_P5_LATCH = 3'b010,
    SEL_P6_LATCH = 3'b011,
    SEL_P4_DIR = 3'b100,
    SEL_P5_DIR = 3'b101,
    SEL_P6_DIR = 3'b110,
    SEL_MEM_EXP = 3'b111
  } reg_sel_t;

endpackage

// *** hdl/port_slice.sv ***
// One general-purpose port: output latch, direction bits, pin drive and
// the value seen by a read. Assumes writes arrive with a per-bit mask, which is applied here.
`timescale 1ns/1ps
module port_slice #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] LATCH_INIT = '0,
  parameter logic [WIDTH-1:0] DIR_INIT = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic latch_we,
  input wire logic dir_we,
  input wire logic [WIDTH-1:0] wmask,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic alt_sel,
  input wire logic [WIDTH-1:0] alt_out,
  input wire logic [WIDTH-1:0] alt_oe,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] rd_value,
  output logic [WIDTH-1:0] dir_value
);

  logic [WIDTH-1:0] latch_reg;
  logic [WIDTH-1:0] latch_next;
  logic [WIDTH-1:0] dir_reg;
  logic [WIDTH-1:0] dir_next;
  logic [WIDTH-1:0] out_next;
  logic [WIDTH-1:0] oe_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    latch_next = latch_reg;
    dir_next = dir_reg;
    if (latch_we) begin
      latch_next = (latch_reg & ~wmask) | (wdata & wmask);
    end
    if (dir_we) begin
      dir_next = (dir_reg & ~wmask) | (wdata & wmask);
    end
  end

  // Pin drive follows the new latch value on the same edge as the write
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign out_next[i] = alt_sel ? alt_out[i] : latch_next[i];
    assign oe_next[i] = alt_sel ? alt_oe[i] : ~dir_next[i];
    assign rd_value[i] = dir_reg[i] ? pin_in[i] : latch_reg[i];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= LATCH_INIT;
      dir_reg <= DIR_INIT;
      pin_out <= LATCH_INIT;
      pin_oe <= '0;
    end else begin
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      pin_out <= out_next;
      pin_oe <= oe_next;
    end
  end

  assign dir_value = dir_reg;

endmodule

// *** bench/gpio_checker.sv ***
// Checker of the expansion bus port block, bound to its top module.
// Assumes it sees only the top module's ports.
`timescale 1ns/1ps
module gpio_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [gpio_pkg::ADDR_W-1:0] addr,
  input wire logic [gpio_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic bit_access,
  input wire logic [gpio_pkg::DATA_W-1:0] rdata,
  input wire logic [gpio_pkg::WIDE_W-1:0] port4_pin_in,
  input wire logic [gpio_pkg::WIDE_W-1:0] port4_pin_out,
  input wire logic [gpio_pkg::WIDE_W-1:0] port4_pin_oe,
  input wire logic [gpio_pkg::WIDE_W-1:0] port5_pin_in,
  input wire logic [gpio_pkg::WIDE_W-1:0] port5_pin_out,
  input wire logic [gpio_pkg::WIDE_W-1:0] port5_pin_oe,
  input wire logic [gpio_pkg::NARROW_W-1:0] port6_pin_out,
  input wire logic [gpio_pkg::NARROW_W-1:0] port6_pin_oe,
  input wire logic [gpio_pkg::AD_W-1:0] multiplexed_addr_data_out,
  input wire logic [gpio_pkg::AD_W-1:0] multiplexed_addr_data_oe,
  input wire logic [gpio_pkg::AD_W-1:0] multiplexed_addr_data_in,
  input wire logic [gpio_pkg::NARROW_W-1:0] upper_address_lines,
  input wire logic [gpio_pkg::MM_W-1:0] memory_expansion_control
);
  logic [1:0] up_reg, up_next;
  logic live;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Counts out the synchronised reset release
  always_comb begin
    up_next = up_reg;
    if (up_reg != 2'h3) begin
      up_next = up_reg + 2'h1;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      up_reg <= 2'h0;
    end else begin
      up_reg <= up_next;
    end
  end
  assign live = (up_reg == 2'h3);

  sequence s_byte_wr(logic [31:0] a);
    wr_stb && !bit_access && addr == a;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (live && !$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_latch_pin: assert property (s_byte_wr(gpio_pkg::PORT4_LATCH_ADDR) ##0
    !memory_expansion_control[0] |=>
    (port4_pin_out & port4_pin_oe) == ($past(wdata) & port4_pin_oe))
    else $error("output pin not driven with written data");
  a_dir_oe: assert property (s_byte_wr(gpio_pkg::PORT4_DIR_ADDR) ##0
    !memory_expansion_control[0] |=> port4_pin_oe == ~$past(wdata))
    else $error("port4 enable does not match direction");
  a_dir6_oe: assert property (s_byte_wr(gpio_pkg::PORT6_DIR_ADDR) ##0
    !memory_expansion_control[2] |=> port6_pin_oe == ~$past(wdata[5:0]))
    else $error("port6 enable does not match direction");
  a_ctrl_write: assert property (s_byte_wr(gpio_pkg::MEM_EXP_CTRL_ADDR)
    |=> memory_expansion_control == $past(wdata[2:0]))
    else $error("control register not written");
  a_bus_low: assert property (live && $past(memory_expansion_control[0])
    |-> port4_pin_out == $past(multiplexed_addr_data_out[7:0]) &&
    port4_pin_oe == $past(multiplexed_addr_data_oe[7:0]))
    else $error("port4 does not follow bus bits 7 to 0");
  a_bus_high: assert property (live && $past(memory_expansion_control[1])
    |-> port5_pin_out == $past(multiplexed_addr_data_out[15:8]) &&
    port5_pin_oe == $past(multiplexed_addr_data_oe[15:8]))
    else $error("port5 does not follow bus bits 15 to 8");
  a_upper_addr: assert property (live && $past(memory_expansion_control[2])
    |-> port6_pin_oe == gpio_pkg::UPPER_OE_ALL &&
    port6_pin_out == $past(upper_address_lines))
    else $error("port6 does not carry upper address");
  a_oe_quiet: assert property (live && !$past(wr_stb) &&
    !$past(memory_expansion_control[0]) &&
    !$past(memory_expansion_control[0], 2) |-> $stable(port4_pin_oe))
    else $error("port4 enable changed without a write");
  a_pins_back: assert property (live |-> multiplexed_addr_data_in ==
    $past({port5_pin_in, port4_pin_in}))
    else $error("bus input does not return pin levels");
endmodule

bind expansion_bus_gpio_ports gpio_checker u_chk (
  .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .bit_access(bit_access), .rdata(rdata),
  .port4_pin_in(port4_pin_in), .port4_pin_out(port4_pin_out),
  .port4_pin_oe(port4_pin_oe), .port5_pin_in(port5_pin_in),
  .port5_pin_out(port5_pin_out), .port5_pin_oe(port5_pin_oe),
  .port6_pin_out(port6_pin_out), .port6_pin_oe(port6_pin_oe),
  .multiplexed_addr_data_out(multiplexed_addr_data_out),
  .multiplexed_addr_data_oe(multiplexed_addr_data_oe),
  .multiplexed_addr_data_in(multiplexed_addr_data_in),
  .upper_address_lines(upper_address_lines),
  .memory_expansion_control(memory_expansion_control)
);

// *** bench/gpio_pin_model.sv ***
// Far side of one port: external circuit that meets the block's pins.
// Assumes the block's enable is high while it drives a pin.
`timescale 1ns/1ps
module gpio_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext_level,
  output logic [W-1:0] pin_in
);
  // Driven bits show the block's value, the rest the outside level only
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// *** bench/test_expansion_bus_gpio_ports.sv ***
// Self-checking bench of the expansion bus port block.
// Assumes the pin model on each port and the bound checker.
`timescale 1ns/1ps
module test_expansion_bus_gpio_ports;
  typedef struct {
    logic wr;
    logic [31:0] a;
    logic bt;
    logic [2:0] ix;
    logic [7:0] d;
  } op_t;
  localparam logic [31:0] L4 = gpio_pkg::PORT4_LATCH_ADDR;
  localparam logic [31:0] L5 = gpio_pkg::PORT5_LATCH_ADDR;
  localparam logic [31:0] L6 = gpio_pkg::PORT6_LATCH_ADDR;
  localparam logic [31:0] D4 = gpio_pkg::PORT4_DIR_ADDR;
  localparam logic [31:0] D5 = gpio_pkg::PORT5_DIR_ADDR;
  localparam logic [31:0] D6 = gpio_pkg::PORT6_DIR_ADDR;
  localparam logic [31:0] MC = gpio_pkg::MEM_EXP_CTRL_ADDR;
  localparam logic [31:0] UN = 32'hffff_f0fe;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] addr = 32'h0000_0000;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic bit_access = 1'b0;
  logic [2:0] bit_index = 3'h0;
  logic [7:0] rdata, got, p4_in, p4_out, p4_oe, p5_in, p5_out, p5_oe;
  logic [5:0] p6_in, p6_out, p6_oe;
  logic [7:0] ext4 = 8'ha5;
  logic [7:0] ext5 = 8'h3c;
  logic [5:0] ext6 = 6'h2a;
  logic [15:0] ad_out = 16'h0000;
  logic [15:0] ad_oe = 16'h0000;
  logic [15:0] ad_in;
  logic [5:0] upper = 6'h00;
  logic [2:0] mem_ctrl;
  int fails = 0;
  int total_checks = 0;
  // Reads carry the expected value in the data field
  op_t rows[] = '{
    '{1'b0, D4, 1'b0, 3'h0, 8'hff}, '{1'b0, D5, 1'b0, 3'h0, 8'hff},
    '{1'b0, D6, 1'b0, 3'h0, 8'h3f}, '{1'b0, L4, 1'b0, 3'h0, 8'ha5},
    '{1'b0, L5, 1'b0, 3'h0, 8'h3c}, '{1'b0, L6, 1'b0, 3'h0, 8'h2a},
    '{1'b0, MC, 1'b0, 3'h0, 8'h00}, '{1'b1, L4, 1'b0, 3'h0, 8'h0f},
    '{1'b0, L4, 1'b0, 3'h0, 8'ha5}, '{1'b1, D4, 1'b0, 3'h0, 8'hf0},
    '{1'b0, L4, 1'b0, 3'h0, 8'haf}, '{1'b1, D5, 1'b1, 3'h7, 8'h00},
    '{1'b0, D5, 1'b0, 3'h0, 8'h7f}, '{1'b0, D5, 1'b1, 3'h7, 8'h00},
    '{1'b0, D5, 1'b1, 3'h0, 8'h01}, '{1'b1, L5, 1'b0, 3'h0, 8'h81},
    '{1'b0, L5, 1'b0, 3'h0, 8'hbc}, '{1'b1, D6, 1'b0, 3'h0, 8'hff},
    '{1'b0, D6, 1'b0, 3'h0, 8'h3f}, '{1'b1, L6, 1'b0, 3'h0, 8'hff},
    '{1'b1, D6, 1'b0, 3'h0, 8'h00}, '{1'b0, L6, 1'b0, 3'h0, 8'h3f},
    '{1'b1, UN, 1'b0, 3'h0, 8'h55}, '{1'b0, UN, 1'b0, 3'h0, 8'h00}};

  expansion_bus_gpio_ports u_dut (
    .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .bit_access(bit_access),
    .bit_index(bit_index), .rdata(rdata), .port4_pin_in(p4_in),
    .port4_pin_out(p4_out), .port4_pin_oe(p4_oe), .port5_pin_in(p5_in),
    .port5_pin_out(p5_out), .port5_pin_oe(p5_oe), .port6_pin_in(p6_in),
    .port6_pin_out(p6_out), .port6_pin_oe(p6_oe),
    .multiplexed_addr_data_out(ad_out), .multiplexed_addr_data_oe(ad_oe),
    .multiplexed_addr_data_in(ad_in), .upper_address_lines(upper),
    .memory_expansion_control(mem_ctrl));
  gpio_pin_model #(.W(8)) u_pm4 (.pin_out(p4_out), .pin_oe(p4_oe),
    .ext_level(ext4), .pin_in(p4_in));
  gpio_pin_model #(.W(8)) u_pm5 (.pin_out(p5_out), .pin_oe(p5_oe),
    .ext_level(ext5), .pin_in(p5_in));
  gpio_pin_model #(.W(6)) u_pm6 (.pin_out(p6_out), .pin_oe(p6_oe),
    .ext_level(ext6), .pin_in(p6_in));

  always #12.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input op_t o, output logic [7:0] rd);
    @(posedge core_clk);
    wr_stb <= o.wr;
    rd_stb <= !o.wr;
    addr <= o.a;
    bit_access <= o.bt;
    bit_index <= o.ix;
    wdata <= o.d;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    #1 rd = rdata;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 4000);
    fails++;
    conclude();
  end

  initial begin
    do_reset();
    foreach (rows[i]) begin
      acc(rows[i], got);
      if (!rows[i].wr) chk("row read", {8'h00, got}, {8'h00, rows[i].d});
    end
    $display("table test done");
    ad_out <= 16'h1234;
    ad_oe <= 16'hffff;
    upper <= 6'h15;
    acc('{1'b1, MC, 1'b0, 3'h0, 8'h07}, got);
    repeat (2) @(posedge core_clk);
    #1;
    chk("control", {13'h0000, mem_ctrl}, 16'h0007);
    chk("port4 bus", {p4_oe, p4_out}, 16'hff34);
    chk("port5 bus", {p5_oe, p5_out}, 16'hff12);
    chk("port6 bus", {2'h0, p6_oe, 2'h0, p6_out}, 16'h3f15);
    chk("bus input", ad_in, 16'h1234);
    acc('{1'b0, D4, 1'b0, 3'h0, 8'h00}, got);
    chk("port4 dir", {8'h00, got}, 16'h00f0);
    acc('{1'b0, D6, 1'b0, 3'h0, 8'h00}, got);
    chk("port6 dir", {8'h00, got}, 16'h0000);
    acc('{1'b1, MC, 1'b0, 3'h0, 8'h00}, got);
    $display("alternate test done");
    do_reset();
    chk("reset oe", {p4_oe, p5_oe}, 16'h0000);
    chk("reset control", {13'h0000, mem_ctrl}, 16'h0000);
    acc('{1'b0, D4, 1'b0, 3'h0, 8'h00}, got);
    chk("reset dir", {8'h00, got}, 16'h00ff);
    acc('{1'b1, D4, 1'b0, 3'h0, 8'h00}, got);
    chk("reset latch", {p4_oe, p4_out}, 16'hff00);
    $display("reset test done");
    conclude();
  end
endmodule
